// File: rsc_consts.vh
// constants of the reset source controller
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

`define RSC_SUPPLY_CTRL_ADDR 8'hff
`define RSC_CAUSE_ADDR       8'hef

`define RSC_SUP_EN_BIT       7
`define RSC_SUP_LVL_BIT      6

`define RSC_PIN_BIT          0
`define RSC_POR_BIT          1
`define RSC_STALL_BIT        2
`define RSC_GUARD_BIT        3
`define RSC_SW_BIT           4
`define RSC_CMP_BIT          5
`define RSC_MEM_BIT          6

`define RSC_SUP_EN_RST       1'b1
`define RSC_CAUSE_RST        8'h02

`define RSC_CLK_PERIOD_NS    40
`define RSC_HOLD_NS          200
`define RSC_GUARD_DIV        12
`define RSC_GUARD_TICKS      256
`define RSC_CODE_LIMIT       16'h7fff

`endif

// File: rsc_sync.v
// two-stage synchroniser for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module rsc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             mclk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// File: rsc_guard_timer.v
// lockup guard timer clocked by core clock / 12
`timescale 1ns/10ps
`default_nettype none
`include "rsc_consts.vh"
module rsc_guard_timer #(
    parameter DIV   = `RSC_GUARD_DIV,
    parameter TICKS = `RSC_GUARD_TICKS
) (
    input  wire mclk,
    input  wire rst_b,
    input  wire restart,
    input  wire service,
    input  wire disable_req,
    output reg  expired
);
    localparam DW = $clog2(DIV);
    localparam TW = $clog2(TICKS + 1);
    localparam DIV_M1  = DIV - 1;
    localparam TICK_M1 = TICKS - 1;
    localparam [DW-1:0] DIV_LAST  = DIV_M1[DW-1:0];
    localparam [TW-1:0] TICK_LAST = TICK_M1[TW-1:0];

    reg [DW-1:0] div_cnt;
    reg [TW-1:0] tick_cnt;
    reg          enabled;
    wire         tick = (div_cnt == DIV_LAST);

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt  <= {DW{1'b0}};
            tick_cnt <= {TW{1'b0}};
            enabled  <= 1'b1;
            expired  <= 1'b0;
        end else if (restart) begin
            // every system reset brings the guard back up running
            div_cnt  <= {DW{1'b0}};
            tick_cnt <= {TW{1'b0}};
            enabled  <= 1'b1;
            expired  <= 1'b0;
        end else begin
            expired <= 1'b0;
            div_cnt <= tick ? {DW{1'b0}} : div_cnt + 1'b1;
            if (disable_req) begin
                enabled <= 1'b0;
            end
            if (service || !enabled) begin
                tick_cnt <= {TW{1'b0}};
            end else if (tick) begin
                if (tick_cnt == TICK_LAST) begin
                    expired  <= 1'b1;
                    tick_cnt <= {TW{1'b0}};
                end else begin
                    tick_cnt <= tick_cnt + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: rsc_reset_source_controller.v
// reset source collection, cause recording and supply monitor control
`timescale 1ns/10ps
`default_nettype none
`include "rsc_consts.vh"
module rsc_reset_source_controller #(
    parameter [15:0] CODE_LIMIT  = `RSC_CODE_LIMIT,
    parameter        GUARD_TICKS = `RSC_GUARD_TICKS
) (
    input  wire        mclk,
    input  wire        rst_b,
    // special-function register port of the core
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    output reg  [7:0]  sfr_rdata,
    // external reset pin, open drain
    input  wire        rst_pin_in,
    output wire        rst_pin_out,
    output wire        rst_pin_oe_b,
    // analog monitors
    input  wire        supply_level_indicator,
    output wire        supply_monitor_enable,
    input  wire        comparator_out,
    input  wire        clock_missing,
    // lockup guard service from the counter array
    input  wire        guard_service,
    input  wire        guard_disable,
    // code-memory accesses: programmer, table read, fetch
    input  wire [2:0]  code_access,
    input  wire [15:0] code_addr,
    // system reset to the rest of the chip
    output reg         sys_rst_b,
    output wire [7:0]  reset_cause
);
    localparam HOLD_CYC_RAW = (`RSC_HOLD_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS;
    localparam HOLD_CYC     = (HOLD_CYC_RAW < 2) ? 2 : HOLD_CYC_RAW;
    localparam CW           = $clog2(HOLD_CYC + 1);
    localparam [CW-1:0] HOLD_LOAD = HOLD_CYC[CW-1:0];
    localparam [CW-1:0] CNT_ONE   = {{(CW-1){1'b0}}, 1'b1};

    // synchronised pin and analog levels
    wire [3:0] lvl_sync;
    wire       pin_high;
    wire       supply_above;
    wire       cmp_high;
    wire       stall_seen;

    // reset pin idles high, monitors idle healthy
    rsc_sync #(
        .WIDTH (4),
        .INIT  (4'h7)
    ) u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     ({clock_missing, comparator_out, supply_level_indicator, rst_pin_in}),
        .q     (lvl_sync)
    );

    assign pin_high     = lvl_sync[0];
    assign supply_above = lvl_sync[1];
    assign cmp_high     = lvl_sync[2];
    assign stall_seen   = lvl_sync[3];

    // control state
    reg          sup_en;
    reg          vdd_sel;
    reg          stall_en;
    reg          cmp_sel;
    reg  [7:0]   cause;
    reg  [7:0]   cause_acc;
    reg  [CW-1:0] hold_cnt;
    reg          active;
    reg          pin_drive;
    reg  [2:0]   pin_mask;
    reg          sw_force;

    wire         guard_expired;
    wire         wr_cause  = sfr_wr && (sfr_addr == `RSC_CAUSE_ADDR) && !active;
    wire         wr_supply = sfr_wr && (sfr_addr == `RSC_SUPPLY_CTRL_ADDR) && !active;

    // the pin reads low for a few cycles after we stop driving it
    wire         pin_own = pin_drive || (pin_mask != 3'h0);

    wire         src_pin   = !pin_high && !pin_own;
    wire         src_vdd   = sup_en && vdd_sel && !supply_above;
    wire         src_stall = stall_en && stall_seen;
    wire         src_cmp   = cmp_sel && !cmp_high;
    wire         src_mem   = (|code_access) && (code_addr > CODE_LIMIT);

    reg  [7:0]   src;
    wire         any_src;

    always @* begin
        src                 = 8'h00;
        src[`RSC_PIN_BIT]   = src_pin;
        src[`RSC_POR_BIT]   = src_vdd;
        src[`RSC_STALL_BIT] = src_stall;
        src[`RSC_GUARD_BIT] = guard_expired;
        src[`RSC_SW_BIT]    = sw_force;
        src[`RSC_CMP_BIT]   = src_cmp;
        src[`RSC_MEM_BIT]   = src_mem;
    end

    assign any_src = |src;

    rsc_guard_timer #(
        .DIV         (`RSC_GUARD_DIV),
        .TICKS       (GUARD_TICKS)
    ) u_guard (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .restart     (active),
        .service     (guard_service),
        .disable_req (guard_disable),
        .expired     (guard_expired)
    );

    // supply monitor enable survives every reset but power-on
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sup_en <= `RSC_SUP_EN_RST;
        end else if (wr_supply) begin
            sup_en <= sfr_wdata[`RSC_SUP_EN_BIT];
        end
    end

    assign supply_monitor_enable = sup_en;

    // source selects; writes only reach the enables of bits 1, 2 and 5 and the bit-4 software strobe
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vdd_sel  <= 1'b0;
            stall_en <= 1'b0;
            cmp_sel  <= 1'b0;
            sw_force <= 1'b0;
        end else begin
            sw_force <= 1'b0;
            if (wr_cause) begin
                vdd_sel  <= sfr_wdata[`RSC_POR_BIT];
                stall_en <= sfr_wdata[`RSC_STALL_BIT];
                cmp_sel  <= sfr_wdata[`RSC_CMP_BIT];
                sw_force <= sfr_wdata[`RSC_SW_BIT];
            end
        end
    end

    // merge sources, stretch, and latch the cause at release
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt  <= HOLD_LOAD;
            active    <= 1'b1;
            cause_acc <= `RSC_CAUSE_RST;
            cause     <= `RSC_CAUSE_RST;
        end else if (any_src) begin
            hold_cnt  <= HOLD_LOAD;
            active    <= 1'b1;
            cause_acc <= cause_acc | src;
        end else if (hold_cnt > CNT_ONE) begin
            hold_cnt  <= hold_cnt - CNT_ONE;
        end else if (active) begin
            hold_cnt  <= {CW{1'b0}};
            active    <= 1'b0;
            // flags not set this time read 0; a power-on mark leaves the rest unqualified
            cause     <= cause_acc;
            cause_acc <= 8'h00;
        end
    end

    // only power-on and supply-monitor resets pull the pin
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_drive <= 1'b1;
            pin_mask  <= 3'h0;
        end else begin
            pin_drive <= (src_vdd || (active && cause_acc[`RSC_POR_BIT])) && !(any_src && !src_vdd
                         && !cause_acc[`RSC_POR_BIT]);
            pin_mask  <= {pin_mask[1:0], pin_drive};
        end
    end

    assign rst_pin_out  = 1'b0;
    assign rst_pin_oe_b = !pin_drive;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sys_rst_b <= 1'b0;
        end else begin
            sys_rst_b <= !(any_src || (hold_cnt > CNT_ONE) || (active && hold_cnt != CNT_ONE));
        end
    end

    assign reset_cause = cause;

    // register reads, one cycle after the strobe
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            if (sfr_addr == `RSC_SUPPLY_CTRL_ADDR) begin
                sfr_rdata <= {sup_en, supply_above, 6'h00};
            end else if (sfr_addr == `RSC_CAUSE_ADDR) begin
                sfr_rdata <= cause;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// File: rsc_props.sv
// assertion checker for the reset source controller
`timescale 1ns/10ps
`default_nettype none
module rsc_props #(
    parameter [15:0] CODE_LIMIT = 16'h7fff
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        rst_pin_in,
    input wire logic        rst_pin_oe_b,
    input wire logic        supply_level_indicator,
    input wire logic        supply_monitor_enable,
    input wire logic [2:0]  code_access,
    input wire logic [15:0] code_addr,
    input wire logic        sys_rst_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_sw_write;
        sfr_wr && sfr_addr == 8'hef && sfr_wdata[4] && sys_rst_b;
    endsequence
    sequence s_sup_steady;
        $stable(supply_level_indicator) [*4];
    endsequence
    chk_sw_forces: assert property (s_sw_write |-> ##[1:3] !sys_rst_b)
        else $error("no software reset");
    chk_mem_limit: assert property ((|code_access) && code_addr > CODE_LIMIT && sys_rst_b |-> ##[1:3] !sys_rst_b)
        else $error("no code memory reset");
    chk_pin_forces: assert property ($fell(rst_pin_in) ##1 !rst_pin_in [*3] |-> !sys_rst_b)
        else $error("no pin reset");
    chk_reset_stretch: assert property ($fell(sys_rst_b) |-> !sys_rst_b [*4])
        else $error("reset too short");
    chk_pin_quiet: assert property (s_sw_write |-> rst_pin_oe_b [*8])
        else $error("pin driven by internal reset");
    chk_sup_enable: assert property (sfr_wr && sfr_addr == 8'hff && sys_rst_b |=>
        supply_monitor_enable == $past(sfr_wdata[7]))
        else $error("enable not written");
    chk_enable_kept: assert property (!sys_rst_b && !$past(sys_rst_b) && $past(rst_b) |->
        $stable(supply_monitor_enable))
        else $error("enable lost in reset");
    chk_ctrl_read: assert property (s_sup_steady ##0 (sfr_rd && sfr_addr == 8'hff) |=>
        sfr_rdata[7:6] == {$past(supply_monitor_enable), $past(supply_level_indicator)})
        else $error("bad control read");
endmodule
bind rsc_reset_source_controller rsc_props #(.CODE_LIMIT(CODE_LIMIT)) u_props (.mclk, .rst_b,
    .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .rst_pin_in, .rst_pin_oe_b,
    .supply_level_indicator, .supply_monitor_enable, .code_access, .code_addr, .sys_rst_b);
`default_nettype wire

// File: rsc_partner.sv
// external reset node with its pull-up
`timescale 1ns/10ps
`default_nettype none
module rsc_partner (
    input  wire logic pin_out,
    input  wire logic pin_oe_b,
    input  wire logic push_low,
    output wire logic pin_level
);
    // pull-up wins unless board or device sinks the node
    assign pin_level = (pin_oe_b | pin_out) & ~push_low;
endmodule
`default_nettype wire

// File: rsc_tb.sv
// self-checking bench for the reset source controller
`timescale 1ns/10ps
`default_nettype none
`define CK(g, w) begin num_checks++; if ((g) !== (w)) begin err_total++; $display("Error %0t: got %h want %h", $time, g, w); end end
module testbench;
    localparam [15:0] LIM = 16'h0fff;
    logic        mclk = 0, rst_b = 0, wr = 0, rd = 0, rd_d = 0, push = 0, sup = 1;
    logic        cmp = 1, miss = 0, svc = 0, gdis = 0, pin_out, oe_b, pin, sup_en, srst;
    logic [7:0]  addr = 0, wdata = 0, rdata, cause, lf = 8'h2d;
    logic [2:0]  acc = 0;
    logic [15:0] caddr = 0;
    logic [15:0] q[$];
    int          err_total = 0, num_checks = 0;
    always #20 mclk = ~mclk;
    rsc_reset_source_controller #(.CODE_LIMIT(LIM), .GUARD_TICKS(4)) u_dut (.mclk(mclk), .rst_b(rst_b),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .rst_pin_in(pin),
        .rst_pin_out(pin_out), .rst_pin_oe_b(oe_b), .supply_level_indicator(sup),
        .supply_monitor_enable(sup_en), .comparator_out(cmp), .clock_missing(miss), .guard_service(svc),
        .guard_disable(gdis), .code_access(acc), .code_addr(caddr), .sys_rst_b(srst), .reset_cause(cause));
    rsc_partner u_part (.pin_out(pin_out), .pin_oe_b(oe_b), .push_low(push), .pin_level(pin));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr8(input logic [7:0] a, d);
        @(negedge mclk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge mclk);
        wr = 0;
    endtask
    task automatic rd8(input logic [7:0] a, m, e);
        q.push_back({m, e});
        @(negedge mclk);
        {addr, rd} = {a, 1'b1};
        @(negedge mclk);
        rd = 0;
        @(negedge mclk);
    endtask
    task automatic await(input logic v);
        int n;
        for (n = 0; n < 300 && srst !== v; n++) @(negedge mclk);
        if (srst !== v) begin
            err_total++;
            summarize();
        end
    endtask
    // guard stopped after each reset so idle stretches stay quiet
    task automatic cycle_rst(input logic [7:0] m, e);
        await(0);
        await(1);
        gdis = 1;
        @(negedge mclk);
        gdis = 0;
        rd8(8'hef, m, e);
        `CK(cause & m, e)
    endtask
    task automatic idle(input logic [7:0] n);
        repeat (n) @(negedge mclk);
    endtask
    // read data lands on the edge that samples the read and is checked at the next falling edge
    always @(posedge mclk) rd_d <= rd;
    always @(negedge mclk) if (rd_d) begin
        logic [15:0] e;
        e = q.pop_front();
        `CK(rdata & e[15:8], e[7:0])
    end
    initial begin
        idle(10);
        rst_b = 1;
        cycle_rst(8'hff, 8'h02);
        rd8(8'h12, 8'hff, 8'h00);
        $display("test power-on finished");
        repeat (4) begin
            lf = lfsr(lf);
            sup = lf[0];
            idle(2);
            wr8(8'hff, lf);
            `CK(sup_en, lf[7])
            rd8(8'hff, 8'hc0, {lf[7], lf[0], 6'h00});
        end
        sup = 1;
        wr8(8'hff, 8'h00);
        wr8(8'hef, 8'h10);
        cycle_rst(8'hff, 8'h10);
        `CK(sup_en, 1'b0)
        wr8(8'hff, 8'h80);
        $display("test supply control finished");
        push = 1;
        idle(5);
        push = 0;
        cycle_rst(8'hff, 8'h01);
        wr8(8'hef, 8'h04);
        miss = 1;
        idle(3);
        miss = 0;
        cycle_rst(8'hff, 8'h04);
        wr8(8'hef, 8'h00);
        {miss, cmp, sup} = 3'b100;
        idle(8);
        `CK(srst, 1'b1)
        {miss, cmp, sup} = 3'b011;
        idle(4);
        wr8(8'hef, 8'h20);
        cmp = 0;
        idle(3);
        `CK(srst, 1'b0)
        `CK(oe_b, 1'b1)
        cmp = 1;
        cycle_rst(8'hff, 8'h20);
        idle(4);
        wr8(8'hef, 8'h02);
        sup = 0;
        idle(3);
        sup = 1;
        cycle_rst(8'h02, 8'h02);
        $display("test source selects finished");
        for (int k = 0; k < 3; k++) begin
            {acc, caddr} = {3'b001 << k, LIM};
            idle(1);
            acc = 0;
            idle(4);
            `CK(srst, 1'b1)
            {acc, caddr} = {3'b001 << k, LIM + 16'h0001};
            idle(1);
            acc = 0;
            cycle_rst(8'hff, 8'h40);
        end
        wr8(8'hef, 8'h10);
        await(0);
        await(1);
        repeat (10) begin
            svc = 1;
            idle(1);
            svc = 0;
            idle(15);
        end
        `CK(srst, 1'b1)
        cycle_rst(8'hff, 8'h08);
        $display("test memory and guard finished");
        wr8(8'hff, 8'h00);
        rst_b = 0;
        idle(2);
        `CK(oe_b, 1'b0)
        `CK(pin_out, 1'b0)
        rst_b = 1;
        cycle_rst(8'hff, 8'h02);
        `CK(sup_en, 1'b1)
        $display("test power cycle finished");
        summarize();
    end
endmodule
`default_nettype wire
